// ===== design/dscr_top.sv
// AXI4-Lite slave holding the switch control and status register.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dscr_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   input  wire logic [1:0]  fault_in,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             channel_a_close,
   output logic             channel_b_close
);
   // ======================================================================
   // Write channel.
   logic       aw_held_reg;
   logic [7:0] aw_addr_reg;
   logic       w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic       bvalid_reg;
   logic [1:0] bresp_reg;
   logic       do_write;
   logic       addr_hit_w;
   logic [1:0] fault_sync1_reg;
   logic [1:0] fault_sync2_reg;

   dscr_wr_if wr ();

   function automatic logic addr_match(input logic [7:0] addr);
      addr_match = (addr[7:2] == dscr_pkg::SWITCH_CONTROL_STATUS_OFFSET[7:2]);
   endfunction : addr_match

   assign s_axi_awready = clk_en && !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = clk_en && !w_held_reg && !bvalid_reg;
   assign do_write      = clk_en && aw_held_reg && w_held_reg && !bvalid_reg;
   assign addr_hit_w    = addr_match(aw_addr_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= dscr_pkg::DATA_ZERO;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= dscr_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= addr_hit_w ? dscr_pkg::RESP_OKAY : dscr_pkg::RESP_SLVERR;
      end else if (clk_en && bvalid_reg && s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign wr.wr_en   = do_write && addr_hit_w;
   assign wr.wr_data = w_data_reg[7:0];
   assign wr.wr_strb = w_strb_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // ======================================================================
   // Fault input synchroniser.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_sync1_reg <= dscr_pkg::FAULT_NONE;
         fault_sync2_reg <= dscr_pkg::FAULT_NONE;
      end else if (clk_en) begin
         fault_sync1_reg <= fault_in;
         fault_sync2_reg <= fault_sync1_reg;
      end
   end

   dscr_store u_store (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .clk_en          (clk_en),
      .fault_in        (fault_sync2_reg),
      .wr              (wr),
      .channel_a_close (channel_a_close),
      .channel_b_close (channel_b_close)
   );

   // ======================================================================
   // Read channel.
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   assign s_axi_arready = clk_en && !rvalid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= dscr_pkg::DATA_ZERO;
         rresp_reg  <= dscr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         if (addr_match(s_axi_araddr)) begin
            rdata_reg <= {24'h00_0000, wr.reg_value};
            rresp_reg <= dscr_pkg::RESP_OKAY;
         end else begin
            rdata_reg <= dscr_pkg::DATA_ZERO;
            rresp_reg <= dscr_pkg::RESP_SLVERR;
         end
      end else if (clk_en && rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   sequence s_write_taken;
      do_write && addr_hit_w;
   endsequence

   a_write_resp_ok: assert property (@(posedge aclk) disable iff (!aresetn)
      s_write_taken |=> (s_axi_bvalid && s_axi_bresp == dscr_pkg::RESP_OKAY))
      else $error("write to register not answered okay");

   a_read_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[5:2] == 4'h0))
      else $error("read data has nonzero reserved bits");

   // ======================================================================
   // Handshake, capture, refusal, freeze, fault and reset checks.
   sequence s_write_miss;
      do_write && !addr_hit_w;
   endsequence

   sequence s_read_hit;
      s_axi_arvalid && s_axi_arready && addr_match(s_axi_araddr);
   endsequence

   sequence s_read_miss;
      s_axi_arvalid && s_axi_arready && !addr_match(s_axi_araddr);
   endsequence

   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   sequence s_aw_first;
      s_axi_awvalid && s_axi_awready && !(s_axi_wvalid && s_axi_wready);
   endsequence

   sequence s_w_first;
      s_axi_wvalid && s_axi_wready && !(s_axi_awvalid && s_axi_awready);
   endsequence

   sequence s_b_waiting;
      s_axi_bvalid && !s_axi_bready;
   endsequence

   sequence s_r_waiting;
      s_axi_rvalid && !s_axi_rready;
   endsequence

   sequence s_enabled_run;
      clk_en ##1 clk_en;
   endsequence

   a_write_resp_err: assert property (@(posedge aclk) disable iff (!aresetn)
      s_write_miss |=> (s_axi_bvalid && s_axi_bresp == dscr_pkg::RESP_SLVERR))
      else $error("unmapped write not refused");

   a_write_miss_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      s_write_miss |-> !wr.wr_en)
      else $error("unmapped write reached the register");

   a_write_strb_skip: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && addr_hit_w && !w_strb_reg[0]) |=>
         ($stable(channel_a_close) && $stable(channel_b_close)))
      else $error("write without low strobe changed a channel");

   a_read_resp_ok: assert property (@(posedge aclk) disable iff (!aresetn)
      s_read_hit |=> (s_axi_rvalid && s_axi_rresp == dscr_pkg::RESP_OKAY &&
         s_axi_rdata[7:0] == $past(wr.reg_value)))
      else $error("register read returned wrong value");

   a_read_resp_err: assert property (@(posedge aclk) disable iff (!aresetn)
      s_read_miss |=> (s_axi_rvalid && s_axi_rresp == dscr_pkg::RESP_SLVERR &&
         s_axi_rdata == dscr_pkg::DATA_ZERO))
      else $error("unmapped read not refused");

   a_both_then_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      s_both_taken ##1 clk_en |=> s_axi_bvalid)
      else $error("write response late");

   a_aw_waits_w: assert property (@(posedge aclk) disable iff (!aresetn)
      s_aw_first |=> (aw_held_reg && !s_axi_bvalid))
      else $error("address alone produced a response");

   a_w_waits_aw: assert property (@(posedge aclk) disable iff (!aresetn)
      s_w_first |=> (w_held_reg && !s_axi_bvalid))
      else $error("data alone produced a response");

   a_aw_captured: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_axi_awready) |=> (aw_addr_reg == $past(s_axi_awaddr)))
      else $error("write address not captured");

   a_w_captured: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_wvalid && s_axi_wready) |=> (w_data_reg == $past(s_axi_wdata) &&
         w_strb_reg == $past(s_axi_wstrb)))
      else $error("write data not captured");

   a_held_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> (!aw_held_reg && !w_held_reg))
      else $error("held write not released");

   a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_b_waiting |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write response dropped before ready");

   a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r_waiting |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
      else $error("read response dropped before ready");

   a_bvalid_single: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && s_axi_bready && clk_en) |=> !s_axi_bvalid)
      else $error("write response repeated");

   a_rvalid_single: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && s_axi_rready && clk_en) |=> !s_axi_rvalid)
      else $error("read response repeated");

   a_arready_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");

   a_awready_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      (aw_held_reg || s_axi_bvalid) |-> !s_axi_awready)
      else $error("address accepted while write pending");

   a_wready_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      (w_held_reg || s_axi_bvalid) |-> !s_axi_wready)
      else $error("data accepted while write pending");

   a_frozen_ready: assert property (@(posedge aclk) disable iff (!aresetn)
      !clk_en |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
      else $error("bus accepted while frozen");

   a_frozen_state: assert property (@(posedge aclk) disable iff (!aresetn)
      !clk_en |=> ($stable(wr.reg_value) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid)))
      else $error("state changed while frozen");

   a_fault_sync: assert property (@(posedge aclk) disable iff (!aresetn)
      s_enabled_run |=> (fault_sync2_reg == $past(fault_in, 2)))
      else $error("fault synchroniser out of step");

   a_fault_reaches: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en ##1 s_enabled_run |=> (wr.reg_value[7:6] == $past(fault_in, 3)))
      else $error("fault pins not reflected in register");

   a_channels_reset: assert property (@(posedge aclk)
      !aresetn |=> (!channel_a_close && !channel_b_close))
      else $error("channels not open after reset");

   a_valids_reset: assert property (@(posedge aclk)
      !aresetn |=> (!s_axi_bvalid && !s_axi_rvalid))
      else $error("responses pending after reset");
endmodule : dscr_top
`default_nettype wire

// ===== shared/dscr_pkg.sv
// Package with register map, field positions and reset values of the switch control block.
// ==========================================================================================
package dscr_pkg;
   localparam logic [7:0]  SWITCH_CONTROL_STATUS_OFFSET = 8'h20;
   localparam logic [7:0]  SWITCH_CONTROL_STATUS_RESET  = 8'h00;
   localparam int          CHANNEL_A_CLOSE_POS          = 0;
   localparam int          CHANNEL_B_CLOSE_POS          = 1;
   localparam int          FAULT_LSB                    = 6;
   localparam logic [1:0]  FAULT_NONE                   = 2'h0;
   localparam logic [1:0]  RESP_OKAY                    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR                  = 2'h2;
   localparam logic [31:0] DATA_ZERO                    = 32'h0000_0000;
endpackage : dscr_pkg

// ===== shared/dscr_wr_if.sv
// Interface carrying an accepted register write from the bus slave to the register store.
`timescale 1ns/1ps
`default_nettype none
interface dscr_wr_if;
   logic       wr_en;
   logic [7:0] wr_data;
   logic [3:0] wr_strb;
   logic [7:0] reg_value;
   modport source (output wr_en, output wr_data, output wr_strb, input reg_value);
   modport sink   (input wr_en, input wr_data, input wr_strb, output reg_value);
endinterface : dscr_wr_if
`default_nettype wire

// ===== design/dscr_store.sv
// Register store for the switch control and status register.
`timescale 1ns/1ps
`default_nettype none
module dscr_store (
   input  wire logic  aclk,
   input  wire logic  aresetn,
   input  wire logic  clk_en,
   input  wire logic  [1:0] fault_in,
   dscr_wr_if.sink    wr,
   output logic       channel_a_close,
   output logic       channel_b_close
);
   logic [1:0] enable_reg;
   logic [1:0] fault_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg <= dscr_pkg::SWITCH_CONTROL_STATUS_RESET[1:0];
      end else if (clk_en && wr.wr_en && wr.wr_strb[0]) begin
         enable_reg <= wr.wr_data[1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_reg <= dscr_pkg::FAULT_NONE;
      end else if (clk_en) begin
         fault_reg <= fault_in;
      end
   end

   assign wr.reg_value = {fault_reg, 4'h0, enable_reg};
   assign channel_a_close = enable_reg[dscr_pkg::CHANNEL_A_CLOSE_POS];
   assign channel_b_close = enable_reg[dscr_pkg::CHANNEL_B_CLOSE_POS];

   a_reset_clears: assert property (@(posedge aclk) !aresetn |=> (wr.reg_value == 8'h00))
      else $error("register not zero after reset");
   a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      wr.reg_value[5:2] == 4'h0)
      else $error("reserved bits not zero");
   a_chan_a_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && wr.wr_en && wr.wr_strb[0]) |=> (channel_a_close == $past(wr.wr_data[0])))
      else $error("channel a did not follow write");
   a_chan_b_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && wr.wr_en && wr.wr_strb[0]) |=> (channel_b_close == $past(wr.wr_data[1])))
      else $error("channel b did not follow write");
   a_hold_no_write: assert property (@(posedge aclk) disable iff (!aresetn)
      !(clk_en && wr.wr_en && wr.wr_strb[0]) |=> $stable(enable_reg))
      else $error("enables changed without write");
   a_fault_track: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> (wr.reg_value[7:6] == $past(fault_in)))
      else $error("fault bits do not track source");
endmodule : dscr_store
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the switch control and status register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [3:0]  strb;
      logic [1:0]  bresp;
      logic [7:0]  rval;
   } dscr_row_t;
   logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, channel_a_close, channel_b_close;
   logic [1:0]  fault_in, s_axi_bresp, s_axi_rresp, resp;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   int          miscompares = 0;
   int          num_checks = 0;
   dscr_row_t   rows [6];
   dscr_top DUT (.aclk, .aresetn, .clk_en, .fault_in, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_a_close,
      .channel_b_close);
   // ==========================================================================
   // Clock and shared tasks.
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %0t: %s", $time, msg);
      end
   endtask : check
   task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int   n;
      logic aw_done, w_done;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_bready <= 1'b1;
      s_axi_wdata <= d; s_axi_wstrb <= s; s_axi_wvalid <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_bvalid === 1'b1) break;
         if (!aw_done && s_axi_awready === 1'b1) begin aw_done = 1'b1; s_axi_awvalid <= 1'b0; end
         if (!w_done && s_axi_wready === 1'b1) begin w_done = 1'b1; s_axi_wvalid <= 1'b0; end
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 50) begin miscompares++; end_sim(); end
   endtask : axi_write
   task axi_read(input logic [7:0] a);
      int   n;
      logic ar_done;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      ar_done = 1'b0;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_rvalid === 1'b1) break;
         if (!ar_done && s_axi_arready === 1'b1) begin ar_done = 1'b1; s_axi_arvalid <= 1'b0; end
      end
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 50) begin miscompares++; end_sim(); end
   endtask : axi_read
   // ==========================================================================
   // Main sequence.
   initial begin
      aresetn = 1'b0; clk_en = 1'b1; fault_in = 2'h0; s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
      rows = '{
         '{8'h20, 32'h0000_0001, 4'hF, dscr_pkg::RESP_OKAY, 8'h01},
         '{8'h20, 32'h0000_0002, 4'hF, dscr_pkg::RESP_OKAY, 8'h02},
         '{8'h20, 32'h0000_0003, 4'h1, dscr_pkg::RESP_OKAY, 8'h03},
         '{8'h20, 32'hFFFF_FFC2, 4'hF, dscr_pkg::RESP_OKAY, 8'h02},
         '{8'h20, 32'h0000_0001, 4'h0, dscr_pkg::RESP_OKAY, 8'h02},
         '{8'h24, 32'h0000_0001, 4'hF, dscr_pkg::RESP_SLVERR, 8'h02}};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(dscr_pkg::SWITCH_CONTROL_STATUS_OFFSET);
      check(rd, 32'h0000_0000, "reset value");
      check(32'({channel_b_close, channel_a_close}), 32'h0000_0000, "reset channels");
      $display("test reset done");
      foreach (rows[i]) begin
         axi_write(rows[i].addr, rows[i].wdata, rows[i].strb);
         check(32'(resp), 32'(rows[i].bresp), "write response");
         axi_read(dscr_pkg::SWITCH_CONTROL_STATUS_OFFSET);
         check(rd, {24'h00_0000, rows[i].rval}, "read back");
         check(32'(resp), 32'(dscr_pkg::RESP_OKAY), "read response");
         check(32'(channel_a_close), 32'(rows[i].rval[0]), "channel a");
         check(32'(channel_b_close), 32'(rows[i].rval[1]), "channel b");
      end
      $display("test rows done");
      axi_read(8'h24);
      check(rd, 32'h0000_0000, "unmapped read data");
      check(32'(resp), 32'(dscr_pkg::RESP_SLVERR), "unmapped read");
      for (int f = 0; f < 4; f++) begin
         @(posedge aclk);
         fault_in <= f[1:0];
         repeat (4) @(posedge aclk);
         axi_read(dscr_pkg::SWITCH_CONTROL_STATUS_OFFSET);
         check(rd, {24'h00_0000, f[1:0], 6'h02}, "fault field");
      end
      $display("test fault done");
      fault_in <= 2'h0;
      repeat (4) @(posedge aclk);
      clk_en <= 1'b0;
      fault_in <= 2'h3;
      repeat (6) @(posedge aclk);
      check(32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h0000_0000, "frozen");
      clk_en <= 1'b1;
      fault_in <= 2'h0;
      axi_read(dscr_pkg::SWITCH_CONTROL_STATUS_OFFSET);
      check(rd, 32'h0000_0002, "frozen fault");
      $display("test freeze done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check(32'({channel_b_close, channel_a_close}), 32'h0000_0000, "mid reset");
      axi_read(dscr_pkg::SWITCH_CONTROL_STATUS_OFFSET);
      check(rd, 32'h0000_0000, "mid reset value");
      $display("test second reset done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
